/* File: design/dpbr_pkg.sv */
/*
  Constants, types and helper functions for the dual-port block memory with FIFO controller.
  Assumes one clock domain and a plain register port owned by the top module.
*/
// Notes on behaviour
// - Two independent ports, each with own address and controls, sharing only array contents.
// - Array runs as one full memory or as two independent half memories.
// - All port inputs are registered on the clock edge before use.
// - Address holds until next operation unless address latching is switched off.
// - Optional output register adds one cycle of read latency.
// - On write the output shows old data, new data, or holds.
// - Unused instance stays powered down; a gate input powers it down dynamically.
// - Full memory shapes run from 32K x1 to 512 x72.
// - Ports may use different shapes; mapping stays consistent over the shared bits.
// - Half memory shapes run from 16K x1 to 512 x36, same features except 64-bit ECC.
// - Widths above 18 (half) or 36 (full) only in split read/write mode.
// - In split read/write mode the write side is fixed at full word width.
// - In 64-bit mode eight Hamming check bits give single correct, double detect.
// - Encoder and decoder usable standalone for external 64/72-bit memories.
// - FIFO flags support common-clock and multirate operation.
// - FIFO advances its own addresses and gives full, empty, almost-full, almost-empty.
// - Almost-full and almost-empty thresholds are set by software.
// - FIFO width and depth configurable; write and read widths may differ.
// - Cascade connections forward accesses to a neighbouring instance.
package dpbr_pkg;
  localparam int WORDS = 512;
  localparam int DW = 72;
  localparam int AW = 16;
  localparam int FW = 17;
  localparam logic [6:0] DATA_BPW = 7'h40;
  localparam logic [6:0] FULL_BPW = 7'h48;
  localparam logic [2:0] RA_CFG = 3'h0;
  localparam logic [2:0] RA_AF = 3'h1;
  localparam logic [2:0] RA_AE = 3'h2;
  localparam logic [2:0] RA_STAT = 3'h3;
  localparam logic [2:0] RA_FILL = 3'h4;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [16:0] AF_RST = 17'h08c00;
  localparam logic [16:0] AE_RST = 17'h00400;
  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_AFULL = 2;
  localparam int ST_AEMPTY = 3;
  localparam int ST_SBE = 4;
  localparam int ST_DBE = 5;
  localparam int ST_SLEEP = 6;
  localparam logic [2:0] K_NARROW_MAX = 3'h2;
  localparam logic [2:0] K_MAX_HALF = 3'h4;
  localparam logic [2:0] K_MAX_FULL = 3'h5;
  localparam logic [2:0] K_ECC = 3'h6;

  typedef enum logic [1:0] {
    WM_READ_FIRST = 2'h0,
    WM_WRITE_FIRST = 2'h1,
    WM_NO_CHANGE = 2'h2
  } dpbr_wm_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [2:0] width_b;
    logic [2:0] width_a;
    logic casc_en;
    logic multirate;
    logic fifo_en;
    logic ecc_en;
    logic split_read_write_mode;
    dpbr_wm_t wm_b;
    dpbr_wm_t wm_a;
    logic out_pipe;
    logic addr_latch_off;
    logic split_halves;
    logic used;
  } dpbr_cfg_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
  } dpbr_req_t;

  // Width codes 0..6 map to 1,2,4,9,18,36,72 bits
  function automatic logic [6:0] dpbr_width(input logic [2:0] k);
    case (k)
      3'h0: return 7'h01;
      3'h1: return 7'h02;
      3'h2: return 7'h04;
      3'h3: return 7'h09;
      3'h4: return 7'h12;
      3'h5: return 7'h24;
      default: return 7'h48;
    endcase
  endfunction

  // Check bits: [7] overall parity, [6:0] Hamming over positions 1..71
  function automatic logic [7:0] dpbr_ecc_gen(input logic [63:0] d);
    logic [6:0] s;
    int j;
    s = 7'h00;
    j = 0;
    for (int pos = 1; pos < 72; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (d[j]) s = s ^ 7'(pos);
        j++;
      end
    end
    return {^{d, s}, s};
  endfunction

  // Returns {dbe, sbe, corrected data}
  function automatic logic [65:0] dpbr_ecc_fix(input logic [71:0] cw);
    logic [7:0] g;
    logic [6:0] s;
    logic perr;
    logic [63:0] d;
    int j;
    d = cw[63:0];
    g = dpbr_ecc_gen(d);
    s = g[6:0] ^ cw[70:64];
    perr = ^cw;
    j = 0;
    for (int pos = 1; pos < 72; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (perr && s == 7'(pos)) d[j] = ~d[j];
        j++;
      end
    end
    return {(s != 7'h00) & ~perr, perr, d};
  endfunction
endpackage

/* File: design/dpbr_top.sv */
/*
  Dual-port block memory: shaped ports, halves, write modes, ECC, FIFO controller, cascade.
  Assumes both user ports and the register port run on REF_CLK; storage is flip-flops.
*/
// The strobed register port and the register offsets were left to the implementer.
module dpbr_top #(
  parameter int WORDS_P = dpbr_pkg::WORDS
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PWR_GATE,
  input dpbr_pkg::dpbr_req_t PA_REQ,
  input dpbr_pkg::dpbr_req_t PB_REQ,
  output logic [dpbr_pkg::DW-1:0] PA_DOUT,
  output logic [dpbr_pkg::DW-1:0] PB_DOUT,
  input wire logic [dpbr_pkg::DW-1:0] CASC_RD_DATA,
  output dpbr_pkg::dpbr_req_t CASC_REQ,
  output logic FIFO_FULL,
  output logic FIFO_EMPTY,
  output logic FIFO_AFULL,
  output logic FIFO_AEMPTY,
  output logic ECC_SBE,
  output logic ECC_DBE,
  input wire logic [63:0] ENC_DATA,
  output logic [7:0] ENC_CHK,
  input wire logic [71:0] DEC_WORD,
  output logic [63:0] DEC_DATA,
  output logic DEC_SBE,
  output logic DEC_DBE,
  input wire logic [2:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);
  import dpbr_pkg::*;

  localparam int WI = $clog2(WORDS_P);

  logic [DW-1:0] mem [WORDS_P];
  dpbr_cfg_t cfg_r;
  logic [FW-1:0] af_thr_r, ae_thr_r;
  logic [FW-1:0] fill_r, fill_d1_r, fill_d2_r, fill_nxt;
  logic [AW-1:0] rptr_r, wptr_r;
  logic full_r, empty_r, afull_r, aempty_r;
  logic sbe_st_r, dbe_st_r, sbe_r, dbe_r;
  logic [31:0] rdata_r;
  dpbr_req_t casc_r;
  logic [7:0] enc_r;
  logic [65:0] dec_r;

  wire asleep = ~cfg_r.used | PWR_GATE;
  wire srw = cfg_r.split_read_write_mode;
  wire split = cfg_r.split_halves;
  wire fifo = cfg_r.fifo_en;
  wire [2:0] kmax = split ? (srw ? K_MAX_FULL : K_MAX_HALF) : (srw ? K_ECC : K_MAX_FULL);
  wire [2:0] kfix = split ? K_MAX_FULL : K_ECC;

  wire [1:0] wr_w, rd_ok_w, sbe_w, dbe_w;
  wire [1:0][WI-1:0] widx_w;
  wire [1:0][DW-1:0] mask_w, wdat_w, dout_w;
  wire [1:0][6:0] wid_w;
  wire [1:0][2:0] k_w;

  ////////////////////////////////////////////////////////////////////////////
  // Ports
  for (genvar p = 0; p < 2; p++) begin : g_port
    dpbr_req_t req;
    logic en_r, we_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] din_r, lat_r, dout_r, rd_nxt;
    logic rd_sbe, rd_dbe;
    assign req = (p == 0) ? PA_REQ : PB_REQ;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        en_r <= 1'b0;
        we_r <= 1'b0;
        addr_r <= '0;
        din_r <= '0;
      end else if (CE) begin
        en_r <= req.en;
        we_r <= req.en & req.we;
        din_r <= req.din;
        if (req.en | cfg_r.addr_latch_off) addr_r <= req.addr;
      end
    end

    wire [2:0] kraw = (p == 0) ? cfg_r.width_a : cfg_r.width_b;
    wire [2:0] k = (srw && p == 1) ? kfix : ((kraw > kmax) ? kmax : kraw);
    wire [6:0] w = dpbr_width(k);
    wire [2:0] lb = 3'h6 - k;
    wire [AW-1:0] addr_eff = fifo ? ((p == 0) ? rptr_r : wptr_r) : addr_r;
    wire [6:0] lane = 7'(addr_eff) & ((7'h01 << lb) - 7'h01);
    wire [6:0] off = 7'(lane * w);
    wire [WI-1:0] wraw = WI'(addr_eff >> lb);
    wire [WI-1:0] widx = split ? {1'(p), wraw[WI-2:0]} : wraw;
    wire [DW-1:0] lmask = (DW'(1) << w) - DW'(1);
    wire ecc = cfg_r.ecc_en && k == K_ECC;
    wire [DW-1:0] din_e = ecc ? {dpbr_ecc_gen(din_r[63:0]), din_r[63:0]} : din_r;
    wire [DW-1:0] old = mem[widx];
    wire [DW-1:0] rslice = (old >> off) & lmask;
    wire [65:0] fix = dpbr_ecc_fix(rslice);
    wire [DW-1:0] rdat = ecc ? {8'h00, fix[63:0]} : rslice;
    // Cascade takes the top address bit; it is ignored in FIFO use
    wire csel = (p == 0) && cfg_r.casc_en && !fifo && addr_r[AW-1];
    wire acc = en_r && !asleep && (!fifo || ((p == 0) ? !empty_r : (we_r && !full_r)));
    wire wr = acc && we_r && !csel && !(srw && p == 0) && !(fifo && p == 0);
    wire rdable = !(srw && p == 1) && !(fifo && p == 1);
    wire [1:0] wm = (p == 0) ? cfg_r.wm_a : cfg_r.wm_b;

    always_comb begin
      rd_nxt = lat_r;
      rd_sbe = 1'b0;
      rd_dbe = 1'b0;
      if (acc) begin
        if (csel) begin
          rd_nxt = CASC_RD_DATA;
        end else if (wr) begin
          if (wm == WM_READ_FIRST) rd_nxt = rdat;
          else if (wm == WM_WRITE_FIRST) rd_nxt = din_r & lmask;
        end else if (rdable) begin
          rd_nxt = rdat;
          rd_sbe = ecc & fix[64];
          rd_dbe = ecc & fix[65];
        end
      end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        lat_r <= '0;
        dout_r <= '0;
      end else if (CE) begin
        lat_r <= rd_nxt;
        dout_r <= cfg_r.out_pipe ? lat_r : rd_nxt;
      end
    end

    assign wr_w[p] = wr;
    assign rd_ok_w[p] = acc && rdable && !csel;
    assign widx_w[p] = widx;
    assign mask_w[p] = lmask << off;
    assign wdat_w[p] = (din_e & lmask) << off;
    assign dout_w[p] = dout_r;
    assign wid_w[p] = w;
    assign k_w[p] = k;
    assign sbe_w[p] = rd_sbe;
    assign dbe_w[p] = rd_dbe;
  end

  assign PA_DOUT = dout_w[0];
  assign PB_DOUT = dout_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // Shared array; a same-word collision merges both lanes, port B wins on overlap
  always_ff @(posedge REF_CLK) begin
    if (CE) begin
      if (wr_w[0]) mem[widx_w[0]] <= (mem[widx_w[0]] & ~mask_w[0]) | wdat_w[0];
      if (wr_w[1]) begin
        if (wr_w[0] && widx_w[0] == widx_w[1])
          mem[widx_w[1]] <= (mem[widx_w[1]] & ~mask_w[0] & ~mask_w[1])
                            | (wdat_w[0] & ~mask_w[1]) | wdat_w[1];
        else
          mem[widx_w[1]] <= (mem[widx_w[1]] & ~mask_w[1]) | wdat_w[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO controller: port B fills, port A drains, counts kept in bits
  wire fwr = fifo & wr_w[1];
  wire frd = fifo & rd_ok_w[0];
  wire [6:0] bpw = (k_w[1] <= K_NARROW_MAX) ? DATA_BPW : FULL_BPW;
  wire [FW-1:0] cap = FW'(int'(bpw) * WORDS_P) >> split;
  wire [FW-1:0] wsz = FW'(wid_w[1]);
  wire [FW-1:0] rsz = FW'(wid_w[0]);
  assign fill_nxt = fill_r + (fwr ? wsz : '0) - (frd ? rsz : '0);
  // Multirate: far-side updates are seen two cycles late, so flags err on the safe side
  wire [FW-1:0] e_base = (cfg_r.multirate && fill_d2_r < fill_nxt) ? fill_d2_r : fill_nxt;
  wire [FW-1:0] f_base = (cfg_r.multirate && fill_d2_r > fill_nxt) ? fill_d2_r : fill_nxt;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fill_r <= '0;
      fill_d1_r <= '0;
      fill_d2_r <= '0;
      rptr_r <= '0;
      wptr_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
      afull_r <= 1'b0;
      aempty_r <= 1'b1;
    end else if (CE) begin
      if (!fifo) begin
        fill_r <= '0;
        rptr_r <= '0;
        wptr_r <= '0;
      end else begin
        fill_r <= fill_nxt;
        if (fwr) wptr_r <= wptr_r + 16'h0001;
        if (frd) rptr_r <= rptr_r + 16'h0001;
      end
      fill_d1_r <= fill_nxt;
      fill_d2_r <= fill_d1_r;
      full_r <= (f_base + wsz) > cap;
      empty_r <= e_base < rsz;
      afull_r <= f_base >= af_thr_r;
      aempty_r <= e_base <= ae_thr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port, ECC status, standalone codec, cascade forwarding
  wire [31:0] stat = {25'h0, asleep, dbe_st_r, sbe_st_r, aempty_r, afull_r, empty_r, full_r};
  wire [31:0] rsel = (REG_ADDR == RA_CFG) ? cfg_r :
                     (REG_ADDR == RA_AF) ? 32'(af_thr_r) :
                     (REG_ADDR == RA_AE) ? 32'(ae_thr_r) :
                     (REG_ADDR == RA_STAT) ? stat :
                     (REG_ADDR == RA_FILL) ? 32'(fill_r) : 32'h0000_0000;
  wire any_sbe = |sbe_w;
  wire any_dbe = |dbe_w;
  wire st_wr = REG_WR && REG_ADDR == RA_STAT;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r <= CFG_RST;
      af_thr_r <= AF_RST;
      ae_thr_r <= AE_RST;
      rdata_r <= '0;
      sbe_st_r <= 1'b0;
      dbe_st_r <= 1'b0;
      sbe_r <= 1'b0;
      dbe_r <= 1'b0;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == RA_CFG) cfg_r <= {13'h0, REG_WDATA[18:0]};
      if (REG_WR && REG_ADDR == RA_AF) af_thr_r <= REG_WDATA[FW-1:0];
      if (REG_WR && REG_ADDR == RA_AE) ae_thr_r <= REG_WDATA[FW-1:0];
      rdata_r <= REG_RD ? rsel : 32'h0000_0000;
      // New error beats a same-cycle write-one clear
      sbe_st_r <= any_sbe | (sbe_st_r & ~(st_wr & REG_WDATA[ST_SBE]));
      dbe_st_r <= any_dbe | (dbe_st_r & ~(st_wr & REG_WDATA[ST_DBE]));
      sbe_r <= any_sbe;
      dbe_r <= any_dbe;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      enc_r <= '0;
      dec_r <= '0;
      casc_r <= '0;
    end else if (CE) begin
      enc_r <= dpbr_ecc_gen(ENC_DATA);
      dec_r <= dpbr_ecc_fix(DEC_WORD);
      casc_r.en <= g_port[0].csel & g_port[0].en_r & ~asleep;
      casc_r.we <= g_port[0].csel & g_port[0].we_r & ~asleep & ~srw;
      casc_r.addr <= {1'b0, g_port[0].addr_r[AW-2:0]};
      casc_r.din <= g_port[0].din_r;
    end
  end

  assign FIFO_FULL = full_r;
  assign FIFO_EMPTY = empty_r;
  assign FIFO_AFULL = afull_r;
  assign FIFO_AEMPTY = aempty_r;
  assign ECC_SBE = sbe_r;
  assign ECC_DBE = dbe_r;
  assign ENC_CHK = enc_r;
  assign DEC_DATA = dec_r[63:0];
  assign DEC_SBE = dec_r[64];
  assign DEC_DBE = dec_r[65];
  assign REG_RDATA = rdata_r;
  assign CASC_REQ = casc_r;
endmodule

/* File: sim/dpbr_top_monitor.sv */
/* Concurrent checks on the ports of the block memory top.
   Assumes one clock domain on REF_CLK and a bind onto dpbr_top. */
module dpbr_top_monitor import dpbr_pkg::*; (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input dpbr_pkg::dpbr_req_t PA_REQ,
  input dpbr_pkg::dpbr_req_t PB_REQ,
  input logic [dpbr_pkg::DW-1:0] PA_DOUT,
  input logic FIFO_FULL,
  input logic FIFO_EMPTY,
  input wire logic [63:0] ENC_DATA,
  input logic [7:0] ENC_CHK,
  input wire logic [71:0] DEC_WORD,
  input logic DEC_SBE,
  input logic DEC_DBE,
  input wire logic [2:0] REG_ADDR,
  input wire logic REG_RD,
  input logic [31:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking mon_cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  chk_rdata_idle: assert property (CE && !REG_RD |=> REG_RDATA == 32'h0)
    else $error("register read data not cleared");
  chk_unmapped_zero: assert property (CE && REG_RD && REG_ADDR > 3'h4 |=> REG_RDATA == 32'h0)
    else $error("unmapped register read not zero");
  chk_flags_excl: assert property (!(FIFO_FULL && FIFO_EMPTY))
    else $error("full and empty together");
  chk_enc_parity: assert property (CE |=> ^{ENC_CHK, $past(ENC_DATA)} == 1'b0)
    else $error("encoder codeword parity odd");
  chk_dec_single: assert property (CE |=> DEC_SBE == $past(^DEC_WORD))
    else $error("decoder single error flag wrong");
  chk_dec_excl: assert property (CE |=> !(DEC_SBE && DEC_DBE))
    else $error("decoder flags both set");
  // Results land one or two edges after capture, so two idle captures freeze the output
  chk_dout_hold: assert property (!$past(PA_REQ.en, 2) && !$past(PA_REQ.en, 3) |-> $stable(PA_DOUT))
    else $error("port A output moved without access");
  chk_empty_hold: assert property ($past(FIFO_EMPTY) && !$past(PB_REQ.en, 2) && !$past(PB_REQ.en, 3)
    && !$past(PB_REQ.en, 4) |-> FIFO_EMPTY)
    else $error("empty dropped without write");
endmodule

bind dpbr_top dpbr_top_monitor mon_u (.REF_CLK, .ARST_N, .CE, .PA_REQ, .PB_REQ, .PA_DOUT,
  .FIFO_FULL, .FIFO_EMPTY, .ENC_DATA, .ENC_CHK, .DEC_WORD, .DEC_SBE, .DEC_DBE, .REG_ADDR,
  .REG_RD, .REG_RDATA);

/* File: sim/dpbr_fabric.sv */
/* Fabric writer that feeds the FIFO through port B with a count pattern.
   Assumes FIFO mode with a 36-bit write side and registered flags. */
module dpbr_fabric import dpbr_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire logic full,
  output dpbr_req_t req,
  output int n_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req = '0;
    n_wr = 0;
    forever begin
      @(posedge clk);
      // Waits for the flag of its last write before the next, at a random pace
      if (go && !full && $urandom % 4 != 0) begin
        req <= '{1'b1, 1'b1, 16'h0, 72'(36'(n_wr) ^ 36'h5a5a5a5a5)};
        @(posedge clk);
        req <= {2'b0, ~req[87:0]};
        n_wr++;
        @(posedge clk);
      end
    end
  end
endmodule

/* File: sim/tb.sv */
/* Self-checking bench: mixed-shape port traffic, codec, FIFO fill and drain.
   Assumes dpbr_top, its bound monitor and the fabric writer; one clock. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dpbr_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, gate = 0, go = 0, rwr = 0, rrd = 0, dsb, ddb, esb, edb;
  logic [2:0] ra = 0;
  logic [31:0] rw = 0, rrdata;
  logic [71:0] casc = 0, dec_w = 0, dout[2], last[2];
  logic [63:0] enc_d = 0, dec_d;
  logic [7:0] enc_c;
  logic [3:0] flg;
  dpbr_req_t pa = '0, pb_tb = '0, pb, fab;
  logic mem [36864];
  int n_errors = 0, comparisons = 0, n_wr, fill, af, lat, kk[2];
  int wid[7] = '{1, 2, 4, 9, 18, 36, 72};
  dpbr_wm_t wm[2];
  assign pb = go ? fab : pb_tb;
  always #50 clk = ~clk;
  always @(posedge clk) casc <= 72'({$urandom, $urandom, $urandom});
  dpbr_top dut_u (.REF_CLK(clk), .ARST_N(rst_n), .CE(ce), .PWR_GATE(gate), .PA_REQ(pa),
    .PB_REQ(pb), .PA_DOUT(dout[0]), .PB_DOUT(dout[1]), .CASC_RD_DATA(casc), .CASC_REQ(),
    .FIFO_FULL(flg[3]), .FIFO_EMPTY(flg[2]), .FIFO_AFULL(flg[1]), .FIFO_AEMPTY(flg[0]),
    .ECC_SBE(esb), .ECC_DBE(edb), .ENC_DATA(enc_d), .ENC_CHK(enc_c), .DEC_WORD(dec_w),
    .DEC_DATA(dec_d), .DEC_SBE(dsb), .DEC_DBE(ddb), .REG_ADDR(ra), .REG_WDATA(rw),
    .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rrdata));
  dpbr_fabric fab_u (.clk(clk), .go(go), .full(flg[3]), .req(fab), .n_wr(n_wr));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [71:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    rwr <= 1;
    ra <= a;
    rw <= d;
    @(posedge clk);
    rwr <= 0;
  endtask
  task automatic reg_chk(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk);
    rrd <= 1;
    ra <= a;
    @(posedge clk);
    rrd <= 0;
    @(negedge clk);
    chk(rrdata, e);
  endtask
  task automatic cfg(bit fifo, int m, bit pipe);
    wm = '{dpbr_wm_t'(m), dpbr_wm_t'((m + 1) % 3)};
    kk = '{5, fifo ? 5 : 2};
    lat = pipe + 1;
    reg_wr(RA_CFG, {13'h0, 3'(kk[1]), 3'h5, 2'h0, fifo, 2'h0, wm[1], wm[0], pipe, 2'h0, 1'b1});
  endtask
  function automatic logic [71:0] rnd();
    return 72'({$urandom, $urandom, $urandom});
  endfunction
  // One port access against the bit-level model of the shared array
  task automatic mop(int p, bit we, int a, logic [71:0] d, bit g);
    logic [71:0] e, old, m;
    int o;
    o = (a >> (6 - kk[p])) * 72 + (a & ((1 << (6 - kk[p])) - 1)) * wid[kk[p]];
    old = '0;
    for (int i = 0; i < wid[kk[p]]; i++) old[i] = mem[o + i];
    m = d & ((72'h1 << wid[kk[p]]) - 72'h1);
    e = g || (we && wm[p] == WM_NO_CHANGE) ? last[p] : we && wm[p] == WM_WRITE_FIRST ? m : old;
    if (we && !g) for (int i = 0; i < wid[kk[p]]; i++) mem[o + i] = m[i];
    @(posedge clk);
    gate <= g;
    if (p) pb_tb <= '{1'b1, we, 16'(a), d};
    else pa <= '{1'b1, we, 16'(a), d};
    @(posedge clk);
    pa <= {2'b0, ~pa[87:0]};
    pb_tb <= {2'b0, ~pb_tb[87:0]};
    for (int i = 1; i <= lat; i++) begin
      @(posedge clk);
      @(negedge clk);
      chk(dout[p], i < lat ? last[p] : e);
    end
    last[p] = e;
    @(posedge clk);
    gate <= 0;
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    n_errors++;
    print_verdict;
  end
  initial begin
    int d;
    logic [71:0] cw;
    void'($urandom(32'hab76a81e));
    last = '{72'h0, 72'h0};
    repeat (2) @(posedge clk);
    rst_n <= 1;
    chk(flg, 4'b0101);
    reg_chk(RA_CFG, CFG_RST);
    reg_chk(RA_AF, 32'(AF_RST));
    reg_chk(RA_AE, 32'(AE_RST));
    reg_chk(RA_STAT, 32'h4a);
    reg_wr(3'h5, 32'hffffffff);
    reg_chk(3'h5, 32'h0);
    $display("test regs done");
    // Every bit of the array gets a known value before random traffic
    cfg(0, 0, 0);
    for (int a = 0; a < 1024; a++) mop(0, 1, a, rnd(), 0);
    for (int m = 0; m < 4; m++) begin
      cfg(0, m % 3, m == 3);
      repeat (150) begin
        d = $urandom % 2;
        mop(d, $urandom % 2, d ? $urandom % 8192 : $urandom % 1024, rnd(), $urandom % 8 == 0);
      end
      $display("test mem pass %0d done", m);
    end
    repeat (20) begin
      @(posedge clk);
      enc_d <= {$urandom, $urandom};
      @(posedge clk);
      @(negedge clk);
      cw = {enc_c, enc_d};
      for (int n = 0; n < 3; n++) begin
        d = $urandom % 72;
        @(posedge clk);
        dec_w <= cw ^ (n > 0 ? 72'h1 << d : 72'h0) ^ (n > 1 ? 72'h1 << (d + 1) % 72 : 72'h0);
        @(posedge clk);
        @(negedge clk);
        chk({ddb, dsb, n < 2 ? dec_d : 64'h0}, {n == 2, n == 1, n < 2 ? enc_d : 64'h0});
      end
    end
    $display("test codec done");
    af = 36 * ($urandom % 1024 + 1);
    cfg(1, 0, 0);
    reg_wr(RA_AF, 32'(af));
    go <= 1;
    for (int i = 0; i < 20000 && flg[3] !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    go <= 0;
    chk(n_wr, 1024);
    reg_chk(RA_STAT, 32'h05);
    @(posedge clk);
    pb_tb <= '{1'b1, 1'b1, 16'h0, rnd()};
    @(posedge clk);
    pb_tb <= {2'b0, ~pb_tb[87:0]};
    reg_chk(RA_FILL, 32'd36864);
    fill = 36864;
    for (int k = 0; k <= 1024; k++) begin
      @(posedge clk);
      pa <= '{1'b1, 1'b0, 16'h0, 72'h0};
      @(posedge clk);
      pa <= {2'b0, ~pa[87:0]};
      @(posedge clk);
      @(negedge clk);
      if (k < 1024) fill -= 36;
      chk(dout[0], 72'(36'(k < 1024 ? k : 1023) ^ 36'h5a5a5a5a5));
      chk(flg, {fill + 36 > 36864, fill < 36, fill >= af, fill <= 1024});
    end
    $display("test fifo done");
    // Raw codeword with one data bit flipped goes in with correction off, is read back with it on
    reg_wr(RA_CFG, 32'h0006c101);
    @(posedge clk);
    pb_tb <= '{1'b1, 1'b1, 16'h5, cw ^ 72'h80};
    @(posedge clk);
    pb_tb <= {2'b0, ~pb_tb[87:0]};
    reg_wr(RA_CFG, 32'h0006c301);
    @(posedge clk);
    pa <= '{1'b1, 1'b0, 16'h5, 72'h0};
    @(posedge clk);
    pa <= {2'b0, ~pa[87:0]};
    @(posedge clk);
    @(negedge clk);
    chk({esb, edb, dout[0][63:0]}, {2'b10, enc_d});
    chk(dout[0][71:64], 8'h00);
    reg_chk(RA_STAT, 32'h1a);
    reg_wr(RA_STAT, 32'h10);
    reg_chk(RA_STAT, 32'h0a);
    $display("test ecc done");
    print_verdict;
  end
endmodule
